// file: design/dma_ctl_regs.vh
// Register offsets, field positions and codes of the channel control word engine
`ifndef DMA_CTL_REGS_VH
`define DMA_CTL_REGS_VH

// ==========================================
// Register byte offsets
`define OFS_CONTROL_WORD   12'h000
`define OFS_CHANNEL_CMD    12'h004
`define OFS_CHANNEL_STATUS 12'h008
`define OFS_FIFO_DATA      12'h00c

// ==========================================
// Control word fields
`define ARB_SIZE_HI        17
`define ARB_SIZE_LO        14
`define COUNT_HI           13
`define COUNT_LO           4
`define NEXT_BURST_BIT     3
`define MODE_HI            2
`define MODE_LO            0

// ==========================================
// Transfer mode codes
`define MODE_STOP          3'h0
`define MODE_BASIC         3'h1
`define MODE_AUTO          3'h2
`define MODE_PERIPH_SG     3'h6

// ==========================================
// Arbitration size codes
`define ARB_CODE_MAX       4'ha
`define ARB_LOG2_MAX       4'ha

// ==========================================
// Command register bits
`define CMD_START_BIT      0
`define CMD_SW_REQ_BIT     1

// ==========================================
// Status register bits
`define ST_BUSY_BIT        0
`define ST_DONE_BIT        1
`define ST_BURST_BIT       2
`define ST_WAIT_BIT        3

// ==========================================
// FIFO sizing
`define FIFO_DEPTH_WORDS   8
`endif

// file: design/word_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge pclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// file: design/arb_size_decode.v
// Arbitration size code to burst length decoder
`timescale 1ns/100ps
`include "dma_ctl_regs.vh"
module arb_size_decode (
	// Code in
	input  wire [3:0]  arb_code,
	// Items per arbitration round, minus one
	output reg  [9:0]  burst_minus_one
);
	reg [3:0] log2len;

	always @* begin
		// Codes above 9 all clamp to 1024, the longest possible cycle
		if (arb_code >= `ARB_CODE_MAX)
			log2len = `ARB_LOG2_MAX;
		else
			log2len = arb_code;
		burst_minus_one = (10'h001 << log2len) - 10'h001;
	end
endmodule

// file: design/dma_channel_engine.v
// Channel engine driven by a control word, with APB registers and data FIFO
`timescale 1ns/100ps
`include "dma_ctl_regs.vh"
module dma_channel_engine #(
	parameter WIDTH = 32,
	parameter DEPTH = `FIFO_DEPTH_WORDS
) (
	// Clock and reset
	input  wire              pclk,
	input  wire              presetn,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [11:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	// Peripheral request
	input  wire              periph_req,
	// Item stream out
	output reg               item_valid,
	input  wire              item_ready,
	output reg  [WIDTH-1:0]  item_data,
	// Channel state
	output reg               busy,
	output reg               burst_only
);
	// ==========================================
	// State codes
	localparam ST_IDLE  = 2'h0;
	localparam ST_ARB   = 2'h1;
	localparam ST_MOVE  = 2'h2;
	localparam ST_WAIT  = 2'h3;

	// ==========================================
	// Control word and status
	reg [31:0]  control_word;
	reg [1:0]   state;
	reg [9:0]   round_left;
	reg         done;
	reg         sw_req;
	reg         single_mode;
	// Working count of items still to move, minus one
	reg [9:0]   remaining;

	wire [2:0]  transfer_mode            = control_word[`MODE_HI:`MODE_LO];
	wire [9:0]  transfer_count_minus_one = control_word[`COUNT_HI:`COUNT_LO];
	wire        next_burst_only          = control_word[`NEXT_BURST_BIT];
	wire [3:0]  arbitration_size         = control_word[`ARB_SIZE_HI:`ARB_SIZE_LO];
	wire [9:0]  burst_minus_one;

	arb_size_decode u_arb (
		.arb_code        (arbitration_size),
		.burst_minus_one (burst_minus_one)
	);

	// ==========================================
	// FIFO in data path
	reg              fill_valid;
	wire             fill_ready;
	reg [WIDTH-1:0]  fill_data;
	wire             drain_valid;
	wire             drain_ready;
	wire [WIDTH-1:0] drain_data;
	reg              fifo_wr;
	reg [WIDTH-1:0]  fifo_wdata;

	word_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH),
		.AW    (3)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (fill_valid),
		.in_ready  (fill_ready),
		.in_data   (fill_data),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_data)
	);

	// Words leave only while moving, one per slot, so every handshake is a counted item
	// Costs half the peak rate, but no word escapes at a round boundary
	assign drain_ready = (state == ST_MOVE) && !item_valid;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			item_valid <= 1'b0;
			item_data  <= {WIDTH{1'b0}};
		end else if (item_valid && item_ready) begin
			item_valid <= 1'b0;
		end else if (drain_ready) begin
			item_valid <= drain_valid;
			if (drain_valid)
				item_data <= drain_data;
		end
	end

	// ==========================================
	// APB access
	wire apb_access = psel && penable;
	wire apb_write  = apb_access && pwrite;
	wire is_ctl     = (paddr == `OFS_CONTROL_WORD);
	wire is_cmd     = (paddr == `OFS_CHANNEL_CMD);
	wire is_sts     = (paddr == `OFS_CHANNEL_STATUS);
	wire is_dat     = (paddr == `OFS_FIFO_DATA);
	wire mapped     = is_ctl || is_cmd || is_sts || is_dat;
	// Data words stall the bus while the FIFO is full
	wire dat_hold   = is_dat && pwrite && !fill_ready;
	wire start_cmd  = apb_write && is_cmd && pwdata[`CMD_START_BIT] && !pready;
	wire req_cmd    = apb_write && is_cmd && pwdata[`CMD_SW_REQ_BIT] && !pready;
	wire request    = periph_req || sw_req;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			fifo_wr <= 1'b0;
			fifo_wdata <= {WIDTH{1'b0}};
		end else begin
			fifo_wr <= 1'b0;
			if (apb_access && !pready && !dat_hold) begin
				pready  <= 1'b1;
				pslverr <= !mapped;
				prdata  <= 32'h0000_0000;
				if (!pwrite) begin
					if (is_ctl)
						prdata <= control_word;
					else if (is_sts)
						prdata <= {28'h0000000, state == ST_WAIT, burst_only, done, busy};
				end else if (is_dat) begin
					fifo_wr    <= 1'b1;
					fifo_wdata <= pwdata[WIDTH-1:0];
				end
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Fill port fed from the registered bus write
	always @* begin
		fill_valid = fifo_wr;
		fill_data  = fifo_wdata;
	end

	// ==========================================
	// Control word: RAM-like storage, no reset
	always @(posedge pclk) begin
		if (apb_write && is_ctl && !pready)
			control_word <= pwdata;
		else if (state == ST_ARB)
			control_word[`COUNT_HI:`COUNT_LO] <= remaining;
		else if (state == ST_MOVE && item_valid && item_ready && remaining != 10'h000)
			control_word[`COUNT_HI:`COUNT_LO] <= remaining - 10'h001;
	end

	// ==========================================
	// Channel sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= ST_IDLE;
			busy        <= 1'b0;
			done        <= 1'b0;
			sw_req      <= 1'b0;
			burst_only  <= 1'b0;
			round_left  <= 10'h000;
			single_mode <= 1'b0;
			remaining   <= 10'h000;
		end else begin
			case (state)
			ST_IDLE: begin
				if (start_cmd) begin
					done <= 1'b0;
					// Stop mode never starts a cycle; every other code, valid or not, does
					if (transfer_mode != `MODE_STOP) begin
						busy      <= 1'b1;
						remaining <= transfer_count_minus_one;
						state     <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (request) begin
					sw_req <= 1'b0;
					state  <= ST_ARB;
				end
			end
			ST_ARB: begin
				// Items in this round: arbitration size or remaining, whichever smaller
				if (remaining <= burst_minus_one) begin
					round_left <= remaining;
					if (remaining != burst_minus_one) begin
						if (next_burst_only && transfer_mode == `MODE_PERIPH_SG) begin
							burst_only  <= 1'b1;
							single_mode <= 1'b0;
						end else
							single_mode <= 1'b1;
					end
				end else
					round_left <= burst_minus_one;
				state <= ST_MOVE;
			end
			ST_MOVE: begin
				if (item_valid && item_ready) begin
					if (remaining == 10'h000) begin
						state       <= ST_IDLE;
						busy        <= 1'b0;
						done        <= 1'b1;
						single_mode <= 1'b0;
					end else begin
						remaining <= remaining - 10'h001;
						if (round_left == 10'h000 || single_mode) begin
							round_left <= 10'h000;
							// Basic needs a new request, auto keeps going
							if (transfer_mode == `MODE_BASIC)
								state <= ST_WAIT;
							else
								state <= ST_ARB;
						end else
							round_left <= round_left - 10'h001;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
			// After the case, so a request written while one is consumed is not lost
			if (req_cmd)
				sw_req <= 1'b1;
		end
	end
endmodule

// file: tb/dma_channel_engine_checker.sv
// Port checker for the channel engine
`timescale 1ns/100ps
module dma_channel_engine_checker #(
	parameter WIDTH = 32,
	parameter DEPTH = 8
) (
	// All ports watched
	input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic              periph_req, item_valid, item_ready, busy, burst_only,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata, prdata,
	input wire logic [WIDTH-1:0]  item_data
);
	// ==========================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready wider than one cycle");
	a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	a_err_unmapped: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr) else $error("unmapped not refused");
	a_ok_mapped: assert property (pready && paddr == 12'h000 |-> !pslverr) else $error("control word refused");
	a_item_hold: assert property (item_valid && !item_ready |=> item_valid && $stable(item_data)) else $error("item lost");
	a_item_busy: assert property (item_valid |-> busy) else $error("item while idle");
	a_burst_sticky: assert property (burst_only |=> burst_only) else $error("burst_only dropped");
	a_burst_busy: assert property ($rose(burst_only) |-> busy || $past(busy)) else $error("burst_only outside cycle");
	cover property (item_valid && item_ready);
	cover property ($rose(burst_only));
	cover property (pready && pslverr);
endmodule
bind dma_channel_engine dma_channel_engine_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
	.item_valid(item_valid), .item_ready(item_ready), .busy(busy), .burst_only(burst_only), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .item_data(item_data));

// file: tb/item_sink.sv
// Item consumer and request source at the far side of the engine
`timescale 1ns/100ps
module item_sink (
	// Control from the bench
	input wire logic         pclk, presetn, slow, req_in,
	// Item stream
	input wire logic         item_valid,
	input wire logic [31:0]  item_data,
	output logic             item_ready, periph_req
);
	// ==========================================
	// Consumer
	int          got = 0;
	logic [31:0] seen [0:63];
	logic [3:0]  cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			item_ready <= 1'b0;
			periph_req <= 1'b0;
		end else begin
			cnt <= cnt + 4'h1;
			// Stalls three cycles in four when slow
			item_ready <= !slow || cnt[1:0] == 2'h3;
			periph_req <= req_in;
			if (item_valid && item_ready) begin
				seen[got % 64] <= item_data;
				got <= got + 1;
			end
		end
	end
endmodule

// file: tb/dma_channel_engine_test.sv
// Self-checking bench for the channel engine
`timescale 1ns/100ps
module dma_channel_engine_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, req_in = 0, err;
	logic        pready, pslverr, item_valid, item_ready, periph_req, busy, burst_only;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, item_data, rd, seed = 32'd74;
	int          fails = 0, checks_done = 0, cyc = 0, base;
	// ==========================================
	// Clock, design and far side
	initial forever #5 pclk = ~pclk;
	dma_channel_engine u_dma_channel_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_req(periph_req), .item_valid(item_valid), .item_ready(item_ready), .item_data(item_data),
		.busy(busy), .burst_only(burst_only));
	item_sink u_item_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .req_in(req_in), .item_valid(item_valid),
		.item_data(item_data), .item_ready(item_ready), .periph_req(periph_req));
	// ==========================================
	// Helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; end
		@(posedge pclk) penable <= 1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 100);
		if (k >= 100) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task report_and_stop();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin fails++; report_and_stop(); end
	end
	// Loads words, starts, then requests again after each round until all items are out
	task transfer(input logic [2:0] mode, input logic [3:0] arb, input logic nb, input int cnt);
		logic [31:0] exp [0:7];
		logic        single;
		int          rsz, tgt, k;
		base = u_item_sink.got;
		rsz = (arb > 4'h9) ? 1024 : 1 << arb;
		single = 1'b0;
		apb(1, 12'h000, {14'h0, arb, 10'(cnt - 1), nb, mode});
		for (k = 0; k < cnt && mode != 3'h0; k++) begin exp[k] = rnd(); apb(1, 12'h00c, exp[k]); end
		apb(1, 12'h004, 32'h3);
		tgt = 0;
		do begin
			// Basic: full rounds while enough remain, then one item per request
			if (mode == 3'h0) tgt = 0;
			else if (mode != 3'h1) tgt = cnt;
			else if (single || cnt - tgt < rsz) begin single = 1'b1; tgt = tgt + 1; end
			else tgt = tgt + rsz;
			k = 0;
			while (u_item_sink.got - base < tgt && k < 3000) begin @(posedge pclk); k++; end
			k = 0;
			do begin apb(0, 12'h008, 0); k++; end while (rd[0] && !rd[3] && k < 50);
			check(u_item_sink.got - base, tgt);
			check({31'h0, busy}, {31'h0, mode != 3'h0 && tgt < cnt});
			if (mode != 3'h0 && tgt < cnt) apb(1, 12'h004, 32'h2);
		end while (mode != 3'h0 && tgt < cnt);
		for (k = 0; k < cnt && mode != 3'h0; k++) check(u_item_sink.seen[(base + k) % 64], exp[k]);
		apb(0, 12'h000, 0);
		check({22'h0, rd[13:4]}, (mode == 3'h0) ? cnt - 1 : 0);
		check({31'h0, burst_only}, {31'h0, nb && mode == 3'h6});
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(1, 12'h000, 32'h0);
		apb(0, 12'h000, 0);
		check(rd, 32'h0);
		apb(0, 12'h010, 0);
		check({31'h0, err}, 32'h1);
		for (int c = 0; c < 16; c++) transfer(3'h1, c[3:0], 1'b0, rnd() % 8 + 1);
		transfer(3'h2, 4'h0, 1'b0, 8);
		transfer(3'h0, 4'h0, 1'b0, 3);
		req_in <= 1;
		slow <= 1;
		transfer(3'h6, 4'h3, 1'b0, 5);
		transfer(3'h6, 4'h3, 1'b1, 5);
		report_and_stop();
	end
endmodule
